/* ipva_arbiter.sv */
`timescale 1ns/10ps
// Behaviour
// - Accept requests from thirteen peripheral kinds
// - Each peripheral source has own vector
// - 4-bit priority per module and line
// - Accepted level becomes new mask level, 15 for level 16
// - Table address is base plus vector*4
// - Encoded levels fixed at 15 to 1
// - External fetch vector limited to 0-127
// - Shared field sources ranked fixed order
// - Reset sets all peripheral priorities zero
// - Equal levels resolved by default ranking
// - Mode bit selects encoded or lines
// - Seven-bit vector fields at 14-8, 6-0
// - Refresh match shares watchdog field, ranks below
// - Encoded auto vectors 71 down to 64, paired; lines 64 to 67
// - Level zero is never accepted
// - Non-maskable is level 16, always taken
module ipva_arbiter #(
   parameter int NUM_PERIPH = 45
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_req,
   input wire logic break_req,
   input wire logic debug_req,
   input wire logic [3:0] ext_pin_n,
   input wire logic [7:0] ext_vector,
   input wire logic [NUM_PERIPH-1:0] periph_req,
   input wire logic [3:0] core_mask_level,
   input wire logic core_ack,
   output ipva_pkg::ipva_core_t core_o,
   output logic irq
);

   if (NUM_PERIPH != ipva_pkg::NSRC)
   begin : g_chk
      $error("NUM_PERIPH must match the source table");
   end

   // Whole state of the block
   typedef struct packed {
      logic [ipva_pkg::NPRI-1:0][3:0] pri;
      logic [ipva_pkg::NSRC-1:0][6:0] vec;
      logic ext_mode;
      logic vec_mode;
      logic [31:0] vbase;
      logic [2:0] stat;
      logic [2:0] msk;
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] pins;
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic req;
      logic [4:0] lvl;
      logic [7:0] vec_o;
      logic [3:0] nmask;
      logic [31:0] addr;
      logic extf;
      ipva_pkg::ipva_cls_t cls;
   } ipva_state_t;

   ipva_state_t st_q;
   ipva_state_t st_d;
   logic acc;
   logic wr;
   logic hit;
   logic [31:0] rd;
   logic [2:0] clr;
   logic [2:0] set;
   logic [4:0] bl;
   logic [7:0] bv;
   logic bx;
   ipva_pkg::ipva_cls_t bc;
   logic [3:0] lvx;
   logic [4:0] pidx;
   logic [5:0] vi;

   // Next state: bus slave, pin filter, arbitration
   always_comb
   begin
      st_d = st_q;
      acc = psel & penable;
      wr = acc & pwrite & st_q.rdy;
      hit = 1'b0;
      rd = '0;
      clr = '0;
      set = '0;
      bl = '0;
      bv = '0;
      bx = 1'b0;
      bc = ipva_pkg::CLS_NONE;
      lvx = '0;
      pidx = '0;
      vi = '0;

      // Pin synchroniser; a change counts once stages agree
      st_d.s1 = ~ext_pin_n;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3)
      begin
         st_d.pins = st_q.s3;
      end

      // priority fields, reserved nibbles read zero
      for (int r = 0; r < 5; r++)
      begin
         if (paddr == ipva_pkg::OFS_PRI_A + 8'(4 * r))
         begin
            hit = 1'b1;
            for (int n = 0; n < 4; n++)
            begin
               pidx = ipva_pkg::PRI_MAP[r][n];
               if (pidx != ipva_pkg::PRI_NONE)
               begin
                  rd[15-4*n -: 4] = st_q.pri[pidx];
                  if (wr)
                  begin
                     st_d.pri[pidx] = pwdata[15-4*n -: 4];
                  end
               end
            end
         end
      end

      // vector words: source 2k-1 high, source 2k low
      // so watchdog interval and refresh share one word
      for (int k = 0; k < ipva_pkg::NVW; k++)
      begin
         if (paddr == ipva_pkg::OFS_VEC0 + 8'(4 * k))
         begin
            hit = 1'b1;
            vi = 6'(2 * k);
            rd[6:0] = st_q.vec[vi];
            if (wr)
            begin
               st_d.vec[vi] = pwdata[6:0];
            end
            // Word 0 holds the divider alone, its high field reads zero
            if (k > 0)
            begin
               rd[14:8] = st_q.vec[vi - 6'h01];
               if (wr)
               begin
                  st_d.vec[vi - 6'h01] = pwdata[14:8];
               end
            end
         end
      end

      // Control, base, status, mask and winner words
      case (paddr)
         ipva_pkg::OFS_CTRL:
         begin
            hit = 1'b1;
            rd[ipva_pkg::CTRL_EXT_MODE] = st_q.ext_mode;
            rd[ipva_pkg::CTRL_VEC_MODE] = st_q.vec_mode;
            if (wr)
            begin
               st_d.ext_mode = pwdata[ipva_pkg::CTRL_EXT_MODE];
               st_d.vec_mode = pwdata[ipva_pkg::CTRL_VEC_MODE];
            end
         end
         ipva_pkg::OFS_VBASE:
         begin
            hit = 1'b1;
            rd = st_q.vbase;
            if (wr)
            begin
               st_d.vbase = pwdata;
            end
         end
         ipva_pkg::OFS_STAT:
         begin
            hit = 1'b1;
            rd[2:0] = st_q.stat;
            if (wr)
            begin
               clr = pwdata[2:0];
            end
         end
         ipva_pkg::OFS_MASK:
         begin
            hit = 1'b1;
            rd[2:0] = st_q.msk;
            if (wr)
            begin
               st_d.msk = pwdata[2:0];
            end
         end
         ipva_pkg::OFS_WIN:
         begin
            hit = 1'b1;
            rd = {st_q.req, 2'b00, st_q.lvl, 8'h00,
               st_q.vec_o, 4'h0, st_q.nmask};
         end
         default:
         begin
            rd = rd;
         end
      endcase

      // Answer one cycle into the access phase
      st_d.rdy = acc & ~st_q.rdy;
      if (acc & ~st_q.rdy)
      begin
         st_d.rdata = rd;
         st_d.err = ~hit;
      end

      // Start at the core mask so only higher levels win
      // strictly above the mask
      bl = {1'b0, core_mask_level};
      // level 16 beats any 4-bit mask
      if (nmi_req && ipva_pkg::LVL_NMI > bl)
      begin
         bl = ipva_pkg::LVL_NMI;
         bv = ipva_pkg::VEC_NMI;
         bc = ipva_pkg::CLS_SYS;
      end
      // strict compare keeps the earlier source on ties
      if (break_req && ipva_pkg::LVL_SYS > bl)
      begin
         bl = ipva_pkg::LVL_SYS;
         bv = ipva_pkg::VEC_BRK;
         bc = ipva_pkg::CLS_SYS;
      end
      if (debug_req && ipva_pkg::LVL_SYS > bl)
      begin
         bl = ipva_pkg::LVL_SYS;
         bv = ipva_pkg::VEC_DBG;
         bc = ipva_pkg::CLS_SYS;
      end

      // external requests follow the selected mode
      if (!st_q.ext_mode)
      begin
         // encoded level is the fixed priority
         lvx = st_q.pins;
         if ({1'b0, lvx} > bl)
         begin
            bl = {1'b0, lvx};
            // adjacent level pairs share one vector
            bv = ipva_pkg::VEC_AUTO + {5'h00, lvx[3:1]};
            bc = ipva_pkg::CLS_EXT;
         end
      end
      else
      begin
         for (int i = 0; i < ipva_pkg::NIRQ; i++)
         begin
            pidx = ipva_pkg::PRI_IRQ0 + 5'(i);
            if (st_q.pins[i] && {1'b0, st_q.pri[pidx]} > bl)
            begin
               bl = {1'b0, st_q.pri[pidx]};
               bv = ipva_pkg::VEC_AUTO + 8'(i);
               bc = ipva_pkg::CLS_EXT;
            end
         end
      end

      // fetched vector keeps only seven bits
      if (bc == ipva_pkg::CLS_EXT && st_q.vec_mode)
      begin
         bx = 1'b1;
         bv = {1'b0, ext_vector[6:0]};
      end

      // same field resolved by index, refresh after interval
      for (int i = 0; i < ipva_pkg::NSRC; i++)
      begin
         lvx = st_q.pri[ipva_pkg::SRC_GRP[i]];
         // level zero never exceeds the mask
         if (periph_req[i] && {1'b0, lvx} > bl)
         begin
            bl = {1'b0, lvx};
            // own vector, top bit always clear
            bv = {1'b0, st_q.vec[i]};
            bx = 1'b0;
            bc = ipva_pkg::CLS_PER;
         end
      end

      st_d.req = bc != ipva_pkg::CLS_NONE;
      st_d.lvl = bl;
      st_d.vec_o = bv;
      st_d.extf = bx;
      st_d.cls = bc;
      // new mask is the accepted level, top at 15
      st_d.nmask = bl[4] ? ipva_pkg::MASK_TOP : bl[3:0];
      st_d.addr = st_q.vbase + {22'h0, bv, 2'b00};

      // Acceptance events; a set beats a same-cycle clear
      if (core_ack && st_q.req)
      begin
         case (st_q.cls)
            ipva_pkg::CLS_SYS: set[ipva_pkg::ST_SYS] = 1'b1;
            ipva_pkg::CLS_EXT: set[ipva_pkg::ST_EXT] = 1'b1;
            ipva_pkg::CLS_PER: set[ipva_pkg::ST_PER] = 1'b1;
            default: set = '0;
         endcase
      end
      st_d.stat = (st_q.stat & ~clr) | set;
   end

   // State register
   // reset clears all priority fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from state
   assign prdata = st_q.rdata;
   assign pready = st_q.rdy;
   assign pslverr = st_q.rdy & st_q.err;
   assign irq = |(st_q.stat & st_q.msk);
   assign core_o.req = st_q.req;
   assign core_o.ext_fetch = st_q.extf;
   assign core_o.new_mask = st_q.nmask;
   assign core_o.vector = st_q.vec_o;
   assign core_o.table_addr = st_q.addr;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence acc_start;
      psel && penable && !pready;
   endsequence
   sequence acc_done;
      pready ##1 !pready;
   endsequence

   apb_answer_a: assert property (acc_start |=> acc_done)
      else $error("bus answer not one cycle late");
   reset_pri_a: assert property (
      $past(!presetn) |-> st_q.pri == '0)
      else $error("priorities not zero after reset");
   nmi_wins_a: assert property (
      nmi_req |=> core_o.req && core_o.vector == 8'h0b)
      else $error("non-maskable request not presented");
   mask_gate_a: assert property (
      st_q.req && st_q.lvl != 5'h10
         |-> st_q.lvl > {1'b0, $past(core_mask_level)})
      else $error("request not above core mask");
   zero_masked_a: assert property (
      core_o.req |-> st_q.lvl != 5'h00)
      else $error("level zero presented");
   vec_range_a: assert property (
      core_o.req |-> !core_o.vector[7])
      else $error("reserved vector produced");
   addr_calc_a: assert property (
      core_o.req |-> core_o.table_addr ==
         $past(st_q.vbase) + {22'h0, core_o.vector, 2'b00})
      else $error("table address wrong");
   auto_vec_a: assert property (
      st_q.req && st_q.cls == ipva_pkg::CLS_EXT && !st_q.extf
         && !$past(st_q.ext_mode)
         |-> st_q.vec_o == 8'h40 + {5'h00, st_q.lvl[3:1]})
      else $error("auto vector wrong");
   new_mask_a: assert property (
      st_q.req |-> st_q.nmask == (st_q.lvl[4] ? 4'hf : st_q.lvl[3:0]))
      else $error("new mask level wrong");
   stat_keep_a: assert property (
      core_ack && st_q.req && st_q.cls == ipva_pkg::CLS_PER
         |=> st_q.stat[2])
      else $error("acceptance event lost");
endmodule

/* ipva_arbiter_test.sv */
`timescale 1ns/10ps
module ipva_arbiter_test;
   typedef struct packed {
      logic [7:0] src;
      logic [3:0] mask;
      logic req;
   } ipva_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic nmi_req = 1'b0;
   logic break_req = 1'b0;
   logic debug_req = 1'b0;
   logic [3:0] ext_pin_n = 4'hf;
   logic [7:0] ext_vector;
   logic [44:0] periph_req = '0;
   logic [3:0] core_mask_level;
   logic core_ack;
   logic ack_en = 1'b0;
   logic load = 1'b0;
   logic [3:0] load_val = 4'h0;
   logic [6:0] fetch_vec = 7'h55;
   ipva_pkg::ipva_core_t core_o;
   logic irq;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic er;
   logic [7:0] va;
   logic [7:0] vb;
   // Level of each shared priority field, as programmed below
   logic [3:0] grp_lvl [0:12] = '{4'h5, 4'ha, 4'h7, 4'h3, 4'hc, 4'h9,
      4'h8, 4'h6, 4'h4, 4'h2, 4'hb, 4'hd, 4'h1};
   // Ordinary cases: source, core mask, whether it is presented
   ipva_row_t rows [0:7] = '{'{8'h00, 4'h4, 1'b1}, '{8'h00, 4'h5, 1'b0},
      '{8'h2c, 4'h0, 1'b1}, '{8'h2c, 4'h1, 1'b0}, '{8'h05, 4'h2, 1'b1},
      '{8'h03, 4'h6, 1'b1}, '{8'h03, 4'h7, 1'b0}, '{8'h0c, 4'h8, 1'b1}};

   ipva_arbiter DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nmi_req(nmi_req), .break_req(break_req), .debug_req(debug_req),
      .ext_pin_n(ext_pin_n), .ext_vector(ext_vector),
      .periph_req(periph_req), .core_mask_level(core_mask_level),
      .core_ack(core_ack), .core_o(core_o), .irq(irq));

   ipva_core_model core (.pclk(pclk), .presetn(presetn), .core_o(core_o),
      .ack_en(ack_en), .load(load), .load_val(load_val),
      .fetch_vec(fetch_vec), .core_mask_level(core_mask_level),
      .core_ack(core_ack), .ext_vector(ext_vector));

   // Clock and hang guard
   always #12.5 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         close_out();
      end
   end

   // Last source gets the top legal vector to probe the 7-bit limit
   function automatic logic [7:0] vec_of(input int s);
      return (s == 44) ? 8'h7f : 8'(s) + 8'h20;
   endfunction

   function automatic logic [3:0] lvl_of(input int s);
      return grp_lvl[ipva_pkg::SRC_GRP[s]];
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask

   // One transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No fixed wait assumed; only the hang guard ends a stuck access
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic set_mask(input logic [3:0] m);
      load <= 1'b1;
      load_val <= m;
      @(posedge pclk);
      load <= 1'b0;
   endtask

   // Pins need four edges through the filter, so six covers all paths
   task automatic see(input logic r, input logic [7:0] v,
      input logic [3:0] m);
      repeat (6) @(posedge pclk);
      chk("req", 32'(core_o.req), 32'(r));
      if (r)
      begin
         chk("vector", 32'(core_o.vector), 32'(v));
         chk("new_mask", 32'(core_o.new_mask), 32'(m));
         chk("addr", core_o.table_addr, 32'h1000 + 32'(v) * 4);
      end
   endtask

   task automatic close_out();
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("pri_reset", rd, 32'h0);
      end
      periph_req <= '1;
      see(1'b0, 8'h00, 4'h0);
      periph_req <= '0;
      apb(1'b0, 8'h28, 32'h0);
      chk("unmapped", 32'(er), 32'h1);
      wr(ipva_pkg::OFS_PRI_A, 32'h5a7f);
      apb(1'b0, ipva_pkg::OFS_PRI_A, 32'h0);
      chk("pri_a", rd, 32'h5a70);
      wr(8'h04, 32'h3c00);
      wr(8'h0c, 32'h9864);
      wr(8'h10, 32'h2bd1);
      wr(ipva_pkg::OFS_VBASE, 32'h1000);
      for (int k = 0; k < 23; k++)
      begin
         va = vec_of(2 * k - 1);
         vb = vec_of(2 * k);
         wr(ipva_pkg::OFS_VEC0 + 8'(4 * k), {17'h0, va[6:0], 1'b0, vb[6:0]});
      end
      foreach (rows[i])
      begin
         set_mask(rows[i].mask);
         periph_req <= 45'h1 << rows[i].src;
         see(rows[i].req, vec_of(rows[i].src), lvl_of(rows[i].src));
      end
      set_mask(4'h0);
      for (int s = 0; s < 45; s++)
      begin
         periph_req <= 45'h1 << s;
         see(1'b1, vec_of(s), lvl_of(s));
      end
      periph_req <= 45'h1e0;
      see(1'b1, vec_of(5), 4'h3);
      periph_req <= 45'h18;
      see(1'b1, vec_of(3), 4'h7);
      periph_req <= 45'h10;
      see(1'b1, vec_of(4), 4'h7);
      wr(8'h04, 32'h5c00);
      periph_req <= 45'h21;
      see(1'b1, vec_of(0), 4'h5);
      set_mask(4'hf);
      nmi_req <= 1'b1;
      see(1'b1, ipva_pkg::VEC_NMI, 4'hf);
      nmi_req <= 1'b0;
      break_req <= 1'b1;
      debug_req <= 1'b1;
      see(1'b0, 8'h00, 4'h0);
      set_mask(4'he);
      see(1'b1, ipva_pkg::VEC_BRK, 4'hf);
      break_req <= 1'b0;
      see(1'b1, ipva_pkg::VEC_DBG, 4'hf);
      debug_req <= 1'b0;
      periph_req <= '0;
      set_mask(4'h0);
      for (int l = 1; l < 16; l++)
      begin
         ext_pin_n <= ~4'(l);
         see(1'b1, ipva_pkg::VEC_AUTO + 8'(l >> 1), 4'(l));
      end
      wr(ipva_pkg::OFS_CTRL, 32'h1);
      wr(8'h08, 32'h3f08);
      ext_pin_n <= 4'b1110;
      see(1'b1, 8'h40, 4'h3);
      ext_pin_n <= 4'b1011;
      see(1'b0, 8'h00, 4'h0);
      ext_pin_n <= 4'b0110;
      see(1'b1, 8'h43, 4'h8);
      wr(ipva_pkg::OFS_CTRL, 32'h3);
      ext_pin_n <= 4'b1101;
      see(1'b1, 8'h55, 4'hf);
      chk("ext_fetch", 32'(core_o.ext_fetch), 32'h1);
      ext_pin_n <= 4'hf;
      wr(ipva_pkg::OFS_CTRL, 32'h0);
      // Accepted request: core adopts its level, so it stops showing
      periph_req <= 45'h1;
      // Let the old external winner drain before the core answers
      see(1'b1, vec_of(0), 4'h5);
      ack_en <= 1'b1;
      repeat (10) @(posedge pclk);
      ack_en <= 1'b0;
      chk("core_mask", 32'(core_mask_level), 32'h5);
      chk("req_after", 32'(core_o.req), 32'h0);
      apb(1'b0, ipva_pkg::OFS_STAT, 32'h0);
      chk("status", rd, 32'h4);
      chk("irq_masked", 32'(irq), 32'h0);
      wr(ipva_pkg::OFS_MASK, 32'h4);
      repeat (2) @(posedge pclk);
      chk("irq_on", 32'(irq), 32'h1);
      periph_req <= '0;
      wr(ipva_pkg::OFS_STAT, 32'h4);
      repeat (2) @(posedge pclk);
      chk("irq_off", 32'(irq), 32'h0);
      // Mid-run reset must drop the programmed levels again
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ipva_pkg::OFS_PRI_A, 32'h0);
      chk("pri_rearm", rd, 32'h0);
      chk("req_rearm", 32'(core_o.req), 32'h0);
      close_out();
   end
endmodule

/* ipva_core_model.sv */
`timescale 1ns/10ps
// Core side: takes a presented request and adopts its level as mask
module ipva_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire ipva_pkg::ipva_core_t core_o,
   input wire logic ack_en,
   input wire logic load,
   input wire logic [3:0] load_val,
   input wire logic [6:0] fetch_vec,
   output logic [3:0] core_mask_level,
   output logic core_ack,
   output logic [7:0] ext_vector
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_mask_level <= 4'h0;
         core_ack <= 1'b0;
         ext_vector <= 8'h00;
      end
      else
      begin
         core_ack <= 1'b0;
         // Top bit held low: a fetched vector never exceeds 127
         ext_vector <= {1'b0, fetch_vec};
         if (load)
            core_mask_level <= load_val;
         else if (ack_en && core_o.req && !core_ack)
         begin
            core_ack <= 1'b1;
            core_mask_level <= core_o.new_mask;
         end
      end
   end
endmodule

/* ipva_pkg.sv */
package ipva_pkg;
   // Source counts and field widths
   localparam int NSRC = 45;
   localparam int NPRI = 17;
   localparam int NVW = 23;
   localparam int NIRQ = 4;
   localparam logic [4:0] PRI_IRQ0 = 5'h0d;
   localparam logic [4:0] PRI_NONE = 5'h1f;
   // Register byte offsets
   localparam logic [7:0] OFS_PRI_A = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [7:0] OFS_VBASE = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1c;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_WIN = 8'h24;
   localparam logic [7:0] OFS_VEC0 = 8'h40;
   // Control word bits
   localparam int CTRL_EXT_MODE = 0;
   localparam int CTRL_VEC_MODE = 1;
   // Status bits: system, external, peripheral accepted
   localparam int ST_SYS = 0;
   localparam int ST_EXT = 1;
   localparam int ST_PER = 2;
   // Fixed levels and vectors
   localparam logic [4:0] LVL_NMI = 5'h10;
   localparam logic [4:0] LVL_SYS = 5'h0f;
   localparam logic [3:0] MASK_TOP = 4'hf;
   localparam logic [7:0] VEC_NMI = 8'h0b;
   localparam logic [7:0] VEC_BRK = 8'h0c;
   localparam logic [7:0] VEC_DBG = 8'h0d;
   localparam logic [7:0] VEC_AUTO = 8'h40;
   // Priority field of each register nibble, high nibble first
   localparam logic [4:0] PRI_MAP [0:4][0:3] = '{
      '{5'h00, 5'h01, 5'h02, 5'h1f},
      '{5'h03, 5'h04, 5'h1f, 5'h1f},
      '{5'h0d, 5'h0e, 5'h0f, 5'h10},
      '{5'h05, 5'h06, 5'h07, 5'h08},
      '{5'h09, 5'h0a, 5'h0b, 5'h0c}};
   // Priority field shared by each peripheral source, default order
   localparam logic [3:0] SRC_GRP [0:44] = '{
      4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3,
      4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5,
      4'h6, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h7,
      4'h8, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9, 4'h9,
      4'ha, 4'ha, 4'ha, 4'ha, 4'hb, 4'hb, 4'hb, 4'hb,
      4'hc, 4'hc, 4'hc, 4'hc};
   typedef enum logic [1:0] {CLS_NONE, CLS_SYS, CLS_EXT, CLS_PER}
      ipva_cls_t;
   // Request bundle towards the core
   typedef struct packed {
      logic req;
      logic ext_fetch;
      logic [3:0] new_mask;
      logic [7:0] vector;
      logic [31:0] table_addr;
   } ipva_core_t;
endpackage
